// *** core/smel_pkg.sv ***
// shared constants for the signal monitor event log
package smel_pkg;
  localparam int CLK_HZ     = 200_000_000;
  localparam int SAMPLE_MS  = 50;
  localparam int HIST_S     = 30;
  localparam int SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int SEC_CYC    = CLK_HZ;
  localparam int HIST_DEPTH = HIST_S * 1000 / SAMPLE_MS;
  localparam int LOG_DEPTH  = 100;
  localparam int PAY_W      = 64;
  localparam int CFG_W      = 40;

  localparam logic [7:0] A_UNITID  = 8'h00;
  localparam logic [7:0] A_TIME    = 8'h04;
  localparam logic [7:0] A_RECSEL  = 8'h08;
  localparam logic [7:0] A_RECINFO = 8'h0C;
  localparam logic [7:0] A_RECTIME = 8'h10;
  localparam logic [7:0] A_RECLO   = 8'h14;
  localparam logic [7:0] A_RECHI   = 8'h18;
  localparam logic [7:0] A_STATUS  = 8'h1C;
  localparam logic [7:0] A_FAULTCH = 8'h20;
  localparam logic [7:0] A_GATES   = 8'h24;
  localparam logic [7:0] A_IRQSTAT = 8'h28;
  localparam logic [7:0] A_IRQMASK = 8'h2C;
  localparam logic [7:0] A_HISTSEL = 8'h30;
  localparam logic [7:0] A_HISTLO  = 8'h34;
  localparam logic [7:0] A_HISTHI  = 8'h38;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] LINE_POWERUP   = 2'h0;
  localparam logic [1:0] LINE_INTERRUPT = 2'h1;
  localparam logic [1:0] LINE_RESTORE   = 2'h2;

  localparam logic [7:0]  CRC_POLY  = 8'h07;
  localparam logic [15:0] UNIT_RST  = 16'h0000;
  localparam logic [6:0]  RECSEL_RST = 7'h01;

  typedef enum logic [1:0] {
    KIND_FAULT  = 2'b00,
    KIND_LINE   = 2'b01,
    KIND_RESET  = 2'b10,
    KIND_CONFIG = 2'b11
  } smel_kind_t;
endpackage : smel_pkg

// *** core/smel_event_log.sv ***
// event log, pre-fault history and monitor gating with AXI4-Lite access
//
// Contract
// - keep at least one hundred event records in retained storage
// - every record carries the date and time of its event
// - log faults, mains line events, resets and configuration changes
// - hold a four-digit 0000-9999 unit id, shown with every record
// - record one is the newest, older records take higher numbers
// - status shows live values, or values frozen at fault plus faulted channels
// - fault record holds type, field states, channels, temperature, voltage, control inputs (code stores only the red field states)
// - line events are power-up, interruption or restore without cold start
// - line records capture mains voltage at the event
// - log a reset record when a fault is cleared by button or input
// - config records hold all config items plus a CRC over them
// - config records flag items changed since the previous config record
// - keep thirty seconds of field states before the fault, every 50 ms
// - sixteen red field monitoring inputs, one per channel
// - red-fail, dual and sequence monitoring only while red enable active
// - either preemption input suppresses only red-fail monitoring
// - invert switch flips sensed polarity of preemption input one
// - logs are delivered on request over the axi4-lite slave to the host
`timescale 1ns/1ps
module smel_event_log #(
  parameter int SAMPLE_CYCLES = smel_pkg::SAMPLE_CYC,
  parameter int SECOND_CYCLES = smel_pkg::SEC_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // field and control pins
  input  wire logic [15:0] fieldGreen,
  input  wire logic [15:0] fieldYellow,
  input  wire logic [15:0] fieldRed,
  input  wire logic        redEnable,
  input  wire logic        flashOverrideInput,
  input  wire logic        preemptOne,
  input  wire logic        preemptTwo,
  input  wire logic        preemptOneInvertSwitch,
  // measurements and event sources
  input  wire logic [7:0]  lineVoltage,
  input  wire logic [7:0]  cabinetTemp,
  input  wire logic        faultTrig,
  input  wire logic [3:0]  faultType,
  input  wire logic [15:0] faultChannels,
  input  wire logic        lineEvent,
  input  wire logic [1:0]  lineKind,
  input  wire logic        resetRequest,
  input  wire logic        configSample,
  input  wire logic [39:0] configWord,
  // gating and interrupt
  output logic             redFailMonitorOn,
  output logic             dualMonitorOn,
  output logic             sequenceMonitorOn,
  output logic             irq
);
  import smel_pkg::*;

  function automatic logic [6:0] recIdx(input logic [6:0] wp, input logic [6:0] n);
    logic [7:0] s;
    s = {1'b0, wp} + 8'(LOG_DEPTH) - {1'b0, n};
    if (s >= 8'(LOG_DEPTH)) s = s - 8'(LOG_DEPTH);
    return s[6:0];
  endfunction : recIdx

  function automatic logic [7:0] crc8(input logic [CFG_W-1:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = CFG_W - 1; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = n[8*b +: 8];
    end
    return r;
  endfunction : merge

  // reset release
  logic [1:0] rstSync_r;
  logic       rstN;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) rstSync_r <= 2'h0;
    else rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstN = rstSync_r[1];

  // pin synchronisers
  logic [52:0] pinS1_r, pinS2_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pinS1_r <= '0;
      pinS2_r <= '0;
    end else begin
      pinS1_r <= {preemptOneInvertSwitch, preemptTwo, preemptOne, flashOverrideInput, redEnable,
                  fieldRed, fieldYellow, fieldGreen};
      pinS2_r <= pinS1_r;
    end
  end
  logic [47:0] fieldS;
  logic        redEnS, ffS, pre1Raw, pre2S, invS, pre1Act, redFailGate, dualGate;
  assign fieldS  = pinS2_r[47:0];
  assign redEnS  = pinS2_r[48];
  assign ffS     = pinS2_r[49];
  assign pre1Raw = pinS2_r[50];
  assign pre2S   = pinS2_r[51];
  assign invS    = pinS2_r[52];
  assign pre1Act = pre1Raw ^ invS;
  assign dualGate    = redEnS & ~ffS;
  assign redFailGate = dualGate & ~pre1Act & ~pre2S;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      redFailMonitorOn  <= 1'b0;
      dualMonitorOn     <= 1'b0;
      sequenceMonitorOn <= 1'b0;
    end else begin
      redFailMonitorOn  <= redFailGate;
      dualMonitorOn     <= dualGate;
      sequenceMonitorOn <= dualGate;
    end
  end

  // axi write path
  logic        awHeld_r, wHeld_r, doWrite, wrOk;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  assign doWrite = awHeld_r & wHeld_r & ~bvalid;
  always_comb begin
    unique case (awAddr_r)
      A_UNITID, A_TIME, A_RECSEL, A_IRQSTAT, A_IRQMASK, A_HISTSEL: wrOk = 1'b1;
      default: wrOk = 1'b0;
    endcase
  end
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end else begin
      awready <= ~awHeld_r & ~(awvalid & awready);
      wready  <= ~wHeld_r & ~(wvalid & wready);
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  logic [31:0] wMerged;
  assign wMerged = merge(32'h0000_0000, wData_r, wStrb_r);

  // unit id, digits above nine are refused
  logic [15:0] unitId_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) unitId_r <= UNIT_RST;
    else if (doWrite && awAddr_r == A_UNITID) begin
      for (int d = 0; d < 4; d++) begin
        if (wStrb_r[d/2] && wData_r[4*d +: 4] <= 4'h9) unitId_r[4*d +: 4] <= wData_r[4*d +: 4];
      end
    end
  end

  // date and time, seconds count set by software
  logic [27:0] secCnt_r;
  logic [31:0] timeNow_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      secCnt_r  <= 28'h0000000;
      timeNow_r <= 32'h0000_0000;
    end else if (doWrite && awAddr_r == A_TIME) begin
      secCnt_r  <= 28'h0000000;
      timeNow_r <= merge(timeNow_r, wData_r, wStrb_r);
    end else if (secCnt_r == 28'(SECOND_CYCLES - 1)) begin
      secCnt_r  <= 28'h0000000;
      timeNow_r <= timeNow_r + 32'h0000_0001;
    end else begin
      secCnt_r <= secCnt_r + 28'h0000001;
    end
  end

  // fault latch and frozen snapshot
  logic        faulted_r;
  logic [3:0]  frzType_r, frzCtl_r;
  logic [7:0]  frzVolt_r, frzTemp_r;
  logic [15:0] frzCh_r, frzRed_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      faulted_r <= 1'b0;
      frzType_r <= 4'h0;
      frzCtl_r  <= 4'h0;
      frzVolt_r <= 8'h00;
      frzTemp_r <= 8'h00;
      frzCh_r   <= 16'h0000;
      frzRed_r  <= 16'h0000;
    end else if (faultTrig) begin
      faulted_r <= 1'b1;
      frzType_r <= faultType;
      frzCtl_r  <= {pre2S, pre1Act, ffS, redEnS};
      frzVolt_r <= lineVoltage;
      frzTemp_r <= cabinetTemp;
      frzCh_r   <= faultChannels;
      frzRed_r  <= fieldS[47:32];
    end else if (resetRequest) begin
      faulted_r <= 1'b0;
    end
  end

  // line and config event capture
  logic [9:0]       lineRec_r;
  logic [PAY_W-1:0] cfgRec_r;
  logic [CFG_W-1:0] lastCfg_r;
  logic             cfgSeen_r, cfgEvent;
  logic [4:0]       cfgDiff;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      cfgDiff[i] = ~cfgSeen_r | (configWord[8*i +: 8] != lastCfg_r[8*i +: 8]);
    end
  end
  assign cfgEvent = configSample & (|cfgDiff);
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      lineRec_r <= 10'h000;
      cfgRec_r  <= '0;
      lastCfg_r <= '0;
      cfgSeen_r <= 1'b0;
    end else begin
      if (lineEvent) lineRec_r <= {lineKind, lineVoltage};
      if (cfgEvent) begin
        cfgRec_r  <= {11'h000, cfgDiff, crc8(configWord), configWord};
        lastCfg_r <= configWord;
        cfgSeen_r <= 1'b1;
      end
    end
  end

  // pending events, one logged per cycle, fault first
  logic [3:0]       pend_r, pendSet, pendClr;
  logic             logWe;
  smel_kind_t       logKind;
  logic [PAY_W-1:0] logPay;
  assign pendSet = {cfgEvent, resetRequest & faulted_r, lineEvent, faultTrig};
  assign logWe   = |pend_r;
  always_comb begin
    pendClr = 4'h0;
    logKind = KIND_FAULT;
    logPay  = {8'h00, frzRed_r, frzCtl_r, frzVolt_r, frzTemp_r, frzCh_r, frzType_r};
    if (pend_r[0]) begin
      pendClr = 4'h1;
    end else if (pend_r[1]) begin
      pendClr = 4'h2;
      logKind = KIND_LINE;
      logPay  = {54'h0, lineRec_r};
    end else if (pend_r[2]) begin
      pendClr = 4'h4;
      logKind = KIND_RESET;
      logPay  = '0;
    end else if (pend_r[3]) begin
      pendClr = 4'h8;
      logKind = KIND_CONFIG;
      logPay  = cfgRec_r;
    end
  end
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) pend_r <= 4'h0;
    else pend_r <= (pend_r & ~pendClr) | pendSet;
  end

  // event record store, circular
  logic [1:0]       logKindMem_r [LOG_DEPTH];
  logic [31:0]      logTimeMem_r [LOG_DEPTH];
  logic [PAY_W-1:0] logPayMem_r  [LOG_DEPTH];
  logic [6:0]       wp_r, recCount_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      wp_r       <= 7'h00;
      recCount_r <= 7'h00;
    end else if (logWe) begin
      wp_r <= (wp_r == 7'(LOG_DEPTH - 1)) ? 7'h00 : wp_r + 7'h01;
      if (recCount_r != 7'(LOG_DEPTH)) recCount_r <= recCount_r + 7'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (logWe) begin
      logKindMem_r[wp_r] <= logKind;
      logTimeMem_r[wp_r] <= timeNow_r;
      logPayMem_r[wp_r]  <= logPay;
    end
  end

  // pre-fault field history, frozen while faulted
  logic [47:0] histMem_r [HIST_DEPTH];
  logic [9:0]  hp_r, histSel_r;
  logic [23:0] sampCnt_r;
  logic        sampTick;
  assign sampTick = (sampCnt_r == 24'(SAMPLE_CYCLES - 1));
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      sampCnt_r <= 24'h000000;
      hp_r      <= 10'h000;
    end else begin
      sampCnt_r <= sampTick ? 24'h000000 : sampCnt_r + 24'h000001;
      if (sampTick && !faulted_r) begin
        hp_r <= (hp_r == 10'(HIST_DEPTH - 1)) ? 10'h000 : hp_r + 10'h001;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sampTick && !faulted_r) histMem_r[hp_r] <= fieldS;
  end
  logic [10:0] histSum;
  logic [9:0]  histIdx;
  always_comb begin
    histSum = {1'b0, hp_r} + 11'(HIST_DEPTH - 1) - {1'b0, histSel_r};
    if (histSum >= 11'(HIST_DEPTH)) histSum = histSum - 11'(HIST_DEPTH);
    histIdx = histSum[9:0];
  end

  // software selections
  logic [6:0] recSel_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      recSel_r  <= RECSEL_RST;
      histSel_r <= 10'h000;
    end else if (doWrite) begin
      if (awAddr_r == A_RECSEL) recSel_r <= wMerged[6:0];
      if (awAddr_r == A_HISTSEL) histSel_r <= (wMerged[9:0] < 10'(HIST_DEPTH)) ? wMerged[9:0] : histSel_r;
    end
  end

  // interrupt status and mask
  logic [3:0] irqStat_r, irqMask_r, irqSet, irqClr;
  assign irqSet = logWe ? pendClr : 4'h0;
  assign irqClr = (doWrite && awAddr_r == A_IRQSTAT) ? wMerged[3:0] : 4'h0;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      irqStat_r <= 4'h0;
      irqMask_r <= 4'h0;
      irq       <= 1'b0;
    end else begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
      if (doWrite && awAddr_r == A_IRQMASK) irqMask_r <= wMerged[3:0];
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  // read path
  logic [6:0]  recAt;
  logic        recValid;
  logic [31:0] rdMux;
  logic        rdOk;
  assign recValid = (recSel_r != 7'h00) && (recSel_r <= recCount_r);
  assign recAt    = recIdx(wp_r, recSel_r);
  always_comb begin
    rdOk  = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (araddr)
      A_UNITID:  rdMux = {16'h0000, unitId_r};
      A_TIME:    rdMux = timeNow_r;
      A_RECSEL:  rdMux = {25'h0, recSel_r};
      A_RECINFO: rdMux = {unitId_r, 6'h00, logKindMem_r[recAt], recValid, recCount_r};
      A_RECTIME: rdMux = logTimeMem_r[recAt];
      A_RECLO:   rdMux = logPayMem_r[recAt][31:0];
      A_RECHI:   rdMux = logPayMem_r[recAt][63:32];
      A_STATUS:  rdMux = faulted_r ? {3'h0, 1'b1, frzType_r, frzCtl_r, 4'h0, frzTemp_r, frzVolt_r}
                                   : {8'h00, pre2S, pre1Act, ffS, redEnS, 4'h0, cabinetTemp, lineVoltage};
      A_FAULTCH: rdMux = faulted_r ? {frzRed_r, frzCh_r} : {fieldS[47:32], 16'h0000};
      A_GATES:   rdMux = {29'h0, sequenceMonitorOn, dualMonitorOn, redFailMonitorOn};
      A_IRQSTAT: rdMux = {28'h0, irqStat_r};
      A_IRQMASK: rdMux = {28'h0, irqMask_r};
      A_HISTSEL: rdMux = {22'h0, histSel_r};
      A_HISTLO:  rdMux = histMem_r[histIdx][31:0];
      A_HISTHI:  rdMux = {16'h0000, histMem_r[histIdx][47:32]};
      default:   rdOk = 1'b0;
    endcase
  end
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdMux;
      rresp   <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  sequence s_resetFromFault;
    resetRequest && faulted_r && !faultTrig;
  endsequence
  sequence s_resetLogged;
    logWe && pendClr == 4'h4;
  endsequence
  property p_redGate;
    1'b1 |=> redFailMonitorOn == $past(redEnS & ~ffS & ~pre1Act & ~pre2S);
  endproperty
  a_redGate: assert property (p_redGate) else $error("red-fail gate wrong");
  property p_preemptKeepsDual;
    (redEnS && !ffS && pre2S) |=> dualMonitorOn && sequenceMonitorOn && !redFailMonitorOn;
  endproperty
  a_preemptKeepsDual: assert property (p_preemptKeepsDual) else $error("preempt gated too much");
  property p_invert;
    (invS && !pre1Raw && !pre2S && redEnS && !ffS) |=> !redFailMonitorOn;
  endproperty
  a_invert: assert property (p_invert) else $error("inverted preempt one not active");
  property p_countGrow;
    (logWe && recCount_r < 7'h64) |=> recCount_r == $past(recCount_r) + 7'h01;
  endproperty
  a_countGrow: assert property (p_countGrow) else $error("record count did not grow");
  property p_newest;
    logWe |=> logTimeMem_r[recIdx(wp_r, 7'h01)] == $past(timeNow_r);
  endproperty
  a_newest: assert property (p_newest) else $error("record one not newest");
  property p_wrap;
    (logWe && wp_r == 7'h63) |=> wp_r == 7'h00 && recCount_r == 7'h64;
  endproperty
  a_wrap: assert property (p_wrap) else $error("log did not wrap");
  property p_resetLog;
    s_resetFromFault |=> ##[0:3] s_resetLogged;
  endproperty
  a_resetLog: assert property (p_resetLog) else $error("reset not logged");
  property p_freeze;
    (faulted_r && !faultTrig) |=> $stable(frzVolt_r) && $stable(hp_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("fault snapshot moved");
  property p_lineVolt;
    lineEvent |=> lineRec_r == {$past(lineKind), $past(lineVoltage)};
  endproperty
  a_lineVolt: assert property (p_lineVolt) else $error("line voltage not captured");
  property p_unitDigits;
    unitId_r[3:0] <= 4'h9 && unitId_r[7:4] <= 4'h9 && unitId_r[11:8] <= 4'h9 && unitId_r[15:12] <= 4'h9;
  endproperty
  a_unitDigits: assert property (p_unitDigits) else $error("unit id digit above nine");
  property p_irq;
    (|(irqStat_r & irqMask_r)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule : smel_event_log

// *** testbench/smel_host_model.sv ***
// axi4-lite host model for register traffic
`timescale 1ns/1ps
module smel_host_model (
  // clock
  input  wire logic        mclk,
  // write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead
endmodule : smel_host_model

// *** testbench/smel_event_log_tb_top.sv ***
// self-checking bench for the signal monitor event log
`timescale 1ns/1ps
module smel_event_log_tb_top;
  import smel_pkg::*;
  logic        mclk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        redEnable, flashOverrideInput, preemptOne, preemptTwo, preemptOneInvertSwitch, irqA;
  logic        faultTrig, lineEvent, resetRequest, configSample;
  logic        redFailMonitorOn, dualMonitorOn, sequenceMonitorOn, irq;
  logic [7:0]  awaddr, araddr, lineVoltage, cabinetTemp;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, faultType;
  logic [1:0]  bresp, rresp, lineKind;
  logic [15:0] fieldGreen, fieldYellow, fieldRed, faultChannels;
  logic [39:0] configWord;
  logic [63:0] pay;
  int          errTotal, compares;
  // {redEn, flash, pre1, pre2, invert, seq, dual, redFail}
  localparam logic [7:0] GATE_ROWS [7] = '{8'h87, 8'h00, 8'hC0, 8'hA6, 8'h96, 8'hAF, 8'h8E};

  smel_event_log #(.SAMPLE_CYCLES(4), .SECOND_CYCLES(8)) dut_u (
    .mclk(mclk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .fieldGreen(fieldGreen), .fieldYellow(fieldYellow), .fieldRed(fieldRed),
    .redEnable(redEnable), .flashOverrideInput(flashOverrideInput), .preemptOne(preemptOne),
    .preemptTwo(preemptTwo), .preemptOneInvertSwitch(preemptOneInvertSwitch), .lineVoltage(lineVoltage),
    .cabinetTemp(cabinetTemp), .faultTrig(faultTrig), .faultType(faultType), .faultChannels(faultChannels),
    .lineEvent(lineEvent), .lineKind(lineKind), .resetRequest(resetRequest), .configSample(configSample),
    .configWord(configWord), .redFailMonitorOn(redFailMonitorOn), .dualMonitorOn(dualMonitorOn),
    .sequenceMonitorOn(sequenceMonitorOn), .irq(irq));

  smel_host_model hostU (
    .mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic [1:0] r;
    hostU.axiWrite(a, d, r);
    check({30'h0, r}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    hostU.axiRead(a, d, r);
    check({30'h0, r}, {30'h0, er});
    if (er === RESP_OKAY) check(d, exp);
  endtask : rd
  task automatic evt(input int w);
    case (w)
      0: faultTrig <= 1'b1;
      1: lineEvent <= 1'b1;
      2: resetRequest <= 1'b1;
      default: configSample <= 1'b1;
    endcase
    tick(1);
    {faultTrig, lineEvent, resetRequest, configSample} <= '0;
    tick(4);
  endtask : evt
  function automatic logic [31:0] info(input logic [1:0] k, input logic [6:0] n);
    return {16'h1234, 6'h0, k, 1'b1, n};
  endfunction : info
  function automatic logic [7:0] crc8(input logic [39:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 39; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction : crc8
  task automatic tally_and_finish();
    $display("compares=%0d errors=%0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #100000;
    errTotal++;
    tally_and_finish();
  end
  initial begin
    rst_b = 1'b0;
    {redEnable, flashOverrideInput, preemptOne, preemptTwo, preemptOneInvertSwitch} = '0;
    {faultTrig, lineEvent, resetRequest, configSample, faultType, lineKind} = '0;
    {fieldGreen, fieldYellow, fieldRed, faultChannels} = 64'h000F_0F00_00F0_0005;
    {lineVoltage, cabinetTemp} = 16'h7819;
    configWord = 40'h0;
    tick(8);
    rst_b <= 1'b1;
    tick(4);
    rd(A_UNITID, {16'h0, UNIT_RST});
    rd(A_RECSEL, {25'h0, RECSEL_RST});
    rd(A_IRQSTAT, 32'h0);
    for (int i = 0; i < 7; i++) begin
      {redEnable, flashOverrideInput, preemptOne, preemptTwo, preemptOneInvertSwitch} <= GATE_ROWS[i][7:3];
      tick(6);
      check({29'h0, sequenceMonitorOn, dualMonitorOn, redFailMonitorOn}, {29'h0, GATE_ROWS[i][2:0]});
    end
    rd(A_GATES, 32'h6);
    wr(A_UNITID, 32'h1234);
    wr(A_UNITID, 32'h12A4);
    rd(A_UNITID, 32'h1234);
    wr(8'h3C, 32'h1, RESP_SLVERR);
    rd(8'h3C, 32'h0, RESP_SLVERR);
    wr(A_STATUS, 32'h1, RESP_SLVERR);
    wr(A_IRQMASK, 32'h0);
    wr(A_TIME, 32'h0000_1000);
    rd(A_TIME, 32'h0000_1000);
    faultType <= 4'h3;
    evt(0);
    irqA = irq;
    lineVoltage <= 8'h70;
    wr(A_IRQMASK, 32'hF);
    tick(2);
    check({31'h0, irq ^ irqA}, 32'h1);
    pay = {8'h00, 16'h00F0, 4'h5, 8'h78, 8'h19, 16'h0005, 4'h3};
    rd(A_RECINFO, info(KIND_FAULT, 7'd1));
    rd(A_RECTIME, 32'h0000_1000);
    rd(A_RECLO, pay[31:0]);
    rd(A_RECHI, pay[63:32]);
    rd(A_STATUS, {4'h1, 4'h3, 4'h5, 4'h0, 16'h1978});
    rd(A_FAULTCH, 32'h00F0_0005);
    fieldGreen <= 16'h00FF;
    tick(12);
    rd(A_HISTLO, 32'h0F00_000F);
    rd(A_HISTHI, 32'h0000_00F0);
    rd(A_IRQSTAT, 32'h1);
    wr(A_IRQSTAT, 32'h1);
    rd(A_IRQSTAT, 32'h0);
    check({31'h0, irq}, 32'h0);
    evt(2);
    rd(A_RECINFO, info(KIND_RESET, 7'd2));
    rd(A_STATUS, {8'h0, 4'h5, 4'h0, 16'h1970});
    rd(A_HISTLO, 32'h0F00_00FF);
    wr(A_HISTSEL, 32'h0000_0258);
    rd(A_HISTSEL, 32'h0);
    wr(A_RECSEL, 32'h2);
    rd(A_RECINFO, info(KIND_FAULT, 7'd2));
    wr(A_RECSEL, 32'h1);
    for (int k = 0; k < 3; k++) begin
      lineKind <= k[1:0];
      evt(1);
      rd(A_RECLO, {22'h0, k[1:0], 8'h70});
    end
    configWord <= 40'h0504030201;
    evt(3);
    rd(A_RECHI, {11'h0, 5'h1F, crc8(40'h0504030201), 8'h05});
    configWord <= 40'h05040302FF;
    evt(3);
    rd(A_RECHI, {11'h0, 5'h01, crc8(40'h05040302FF), 8'h05});
    evt(3);
    rd(A_RECINFO, info(KIND_CONFIG, 7'd7));
    repeat (100) evt(1);
    rd(A_RECINFO, info(KIND_LINE, 7'd100));
    wr(A_RECSEL, 32'd100);
    rd(A_RECINFO, info(KIND_LINE, 7'd100));
    rd(A_RECLO, {22'h0, 2'h2, 8'h70});
    tally_and_finish();
  end
endmodule : smel_event_log_tb_top
